// *** hdl/bbps_top.sv ***
// Buck/boost PWM supervisor: drive steering, protection and switching clock source
//
// Summary of operation
// - Hiccup after over 500 consecutive over-limit cycles
// - Hiccup suspends switching 500 cycles, then restarts
// - Restart resumes only after soft-start passes threshold
// - Master role: own rate, clock out on pin
// - Emitted timing clock has half-period high phase
// - Timing pin open-drain: pull low or release
// - Slave role: lock cycle to external clock edge
// - Shift role: lock to delayed external clock edge
// - Own switching rate limited to 50-300 kHz
// - Duty ceiling programmable, never above 98 percent
// - Fault low: stop, drives low, soft-start reset
// - Fault high again: restart from soft-start reset
// - Over-temperature: drives low, discharge soft-start
// - Over-temperature release restarts the control loop
// - Mode low selects boost, high selects buck
// - Mode changes only while disabled or shut down
// - Current-limit reference chosen by latched mode
// - Boost pulses low side; buck pulses high side
// - Mode captured on rail and fault rising edges
// - Soft-start gates switching and limits duty
// - Error input: off, proportional, or full ceiling
`timescale 1ns/100ps
`default_nettype none

module bbps_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic enable_ind,
  input wire logic low_supply_lockout,
  input wire logic fault_n,
  input wire logic over_temperature_shutdown,
  input wire logic internal_rail,
  input wire logic mode_buck_ind,
  input wire logic cl_over_ind,
  input wire logic ss_ready_ind,
  input wire logic error_low_ind,
  input wire logic error_high_ind,
  input wire logic [1:0] clock_role_select_level,
  input wire logic [9:0] rate_set_pin,
  input wire logic [9:0] phase_delay_pin,
  input wire logic [6:0] duty_ceiling_pin,
  input wire logic [6:0] error_duty_pct,
  input wire logic [6:0] ss_duty_pct,
  input wire logic timing_pin_i,
  output logic timing_pin_o,
  output logic timing_pin_oe_n,
  output logic high_side_drive,
  output logic low_side_drive,
  output logic ss_discharge,
  output logic cl_ref_boost_sel,
  output logic buck_mode,
  output logic hiccup_active,
  output logic regulating
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int SYNC_W = 53;  // Total synchronised input bits

  logic s_en;                   // Enable
  logic s_lock;                 // Supply lockout
  logic s_fault_n;              // External fault, low means fault
  logic s_tsd;                  // Over-temperature shutdown
  logic s_rail;                 // Internal rail good
  logic s_mode;                 // Mode level, high means buck
  logic s_cl;                   // Peak current over limit
  logic s_ss;                   // Soft-start above switching threshold
  logic s_err_lo;               // Error input below range
  logic s_err_hi;               // Error input above range
  logic [1:0] s_role;           // Clock role level code
  logic [9:0] s_rate;           // Requested period in core cycles
  logic [9:0] s_phase;          // Phase delay in core cycles
  logic [6:0] s_duty_ceiling_pin;           // Duty ceiling setting
  logic [6:0] s_err_duty;       // Duty asked by the error input
  logic [6:0] s_ss_duty;        // Duty allowed by the soft-start ramp
  logic [SYNC_W-1:0] sync_out;  // Synchroniser bank output
  logic edge_tgl;               // Link-domain edge toggle
  logic tgl_sync;               // Toggle after two core flops
  logic tgl_prev_reg;           // Toggle one core cycle earlier
  logic ext_pulse;              // One core cycle per outside clock rising edge

  // Static and comparator inputs all cross through two flops
  bbps_sync #(.W(SYNC_W)) u_in_sync (
    .clk(clk),
    .srst(srst),
    .d_in({enable_ind, low_supply_lockout, fault_n, over_temperature_shutdown,
           internal_rail, mode_buck_ind, cl_over_ind, ss_ready_ind, error_low_ind,
           error_high_ind, clock_role_select_level, rate_set_pin, phase_delay_pin,
           duty_ceiling_pin, error_duty_pct, ss_duty_pct}),
    .q_out(sync_out)
  );

  assign {s_en, s_lock, s_fault_n, s_tsd, s_rail, s_mode, s_cl, s_ss, s_err_lo, s_err_hi,
          s_role, s_rate, s_phase, s_duty_ceiling_pin, s_err_duty, s_ss_duty} = sync_out;

  // Timing pin edges are caught on the link clock
  bbps_link_edge u_link (
    .link_clk(link_clk),
    .srst(srst),
    .pin_in(timing_pin_i),
    .edge_tgl(edge_tgl)
  );

  // Toggle crosses to the core clock through two flops
  bbps_sync #(.W(1)) u_tgl_sync (
    .clk(clk),
    .srst(srst),
    .d_in(edge_tgl),
    .q_out(tgl_sync)
  );

  // Remember toggle to turn each change into a pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      tgl_prev_reg <= 1'b0;
    end else begin
      tgl_prev_reg <= tgl_sync;
    end
  end

  assign ext_pulse = tgl_sync ^ tgl_prev_reg;

  // ------------------------------------------------------------
  // Disable causes and mode latch
  // ------------------------------------------------------------
  logic disabled;      // Any cause that forces the off state
  logic rail_prev_reg; // Rail level one cycle earlier
  logic fault_prev_reg;// Fault level one cycle earlier
  logic mode_reg;      // Latched mode, high means buck

  // Enable, lockout, fault, over-temperature and missing rail all disable
  assign disabled = !s_en || s_lock || !s_fault_n || s_tsd || !s_rail;

  // Edge history of rail and fault levels
  always_ff @(posedge clk) begin
    if (srst) begin
      rail_prev_reg <= 1'b0;
      fault_prev_reg <= 1'b0;
    end else begin
      rail_prev_reg <= s_rail;
      fault_prev_reg <= s_fault_n;
    end
  end

  // Mode is captured only on a rising rail or fault edge, then held
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= 1'b1;
    end else if ((s_rail && !rail_prev_reg) || (s_fault_n && !fault_prev_reg)) begin
      mode_reg <= s_mode;
    end
  end

  assign buck_mode = mode_reg;
  assign cl_ref_boost_sel = !mode_reg;

  // ------------------------------------------------------------
  // Switching cycle timing
  // ------------------------------------------------------------
  bbps_pkg::bbps_role_t role_reg;  // Current clock role
  logic [9:0] cnt_reg;             // Position within the switching cycle
  logic [9:0] period_reg;          // Own programmed period
  logic [9:0] delay_cnt_reg;       // Remaining phase delay
  logic delay_busy_reg;            // Phase delay running
  logic delay_done;                // Phase delay expired this cycle
  logic own_wrap;                  // Own period elapsed
  logic cyc_start;                 // Last core cycle of the switching cycle now ending
  logic [9:0] len_now;             // Length of the cycle now ending

  assign own_wrap = (cnt_reg >= (period_reg - bbps_pkg::CNT_ONE));
  assign delay_done = delay_busy_reg && (delay_cnt_reg == bbps_pkg::CNT_ZERO);
  assign len_now = cnt_reg + bbps_pkg::CNT_ONE;

  // Master runs on its own period; slave restarts on outside edges, shift when the phase delay expires
  always_comb begin
    case (role_reg)
      bbps_pkg::BBPS_ROLE_MASTER: cyc_start = own_wrap;
      bbps_pkg::BBPS_ROLE_SLAVE: cyc_start = ext_pulse || own_wrap;
      bbps_pkg::BBPS_ROLE_SHIFT: cyc_start = delay_done || own_wrap;
      default: cyc_start = own_wrap;
    endcase
  end

  // Role and period are taken once per switching cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      role_reg <= bbps_pkg::BBPS_ROLE_MASTER;
      period_reg <= bbps_pkg::PERIOD_MAX;
    end else if (cyc_start) begin
      period_reg <= bbps_pkg::bbps_clamp_period(s_rate);
      case (s_role)
        bbps_pkg::ROLE_CODE_MASTER: role_reg <= bbps_pkg::BBPS_ROLE_MASTER;
        bbps_pkg::ROLE_CODE_SLAVE: role_reg <= bbps_pkg::BBPS_ROLE_SLAVE;
        bbps_pkg::ROLE_CODE_SHIFT: role_reg <= bbps_pkg::BBPS_ROLE_SHIFT;
        default: role_reg <= role_reg;  // Level between bands keeps the role
      endcase
    end
  end

  // Cycle position counter; a near-rate outside clock keeps restarting it
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= bbps_pkg::CNT_ZERO;
    end else if (cyc_start) begin
      cnt_reg <= bbps_pkg::CNT_ZERO;
    end else begin
      cnt_reg <= cnt_reg + bbps_pkg::CNT_ONE;
    end
  end

  // Phase delay starts on each outside rising edge in shift role
  always_ff @(posedge clk) begin
    if (srst) begin
      delay_cnt_reg <= bbps_pkg::CNT_ZERO;
      delay_busy_reg <= 1'b0;
    end else if (ext_pulse && (role_reg == bbps_pkg::BBPS_ROLE_SHIFT)) begin
      delay_cnt_reg <= s_phase;
      delay_busy_reg <= 1'b1;
    end else if (delay_done) begin
      delay_busy_reg <= 1'b0;
    end else if (delay_busy_reg) begin
      delay_cnt_reg <= delay_cnt_reg - bbps_pkg::CNT_ONE;
    end
  end

  // ------------------------------------------------------------
  // Timing pin output in master role
  // ------------------------------------------------------------
  // Released for the first half of the period, pulled low for the second
  always_ff @(posedge clk) begin
    if (srst) begin
      timing_pin_oe_n <= 1'b1;
      timing_pin_o <= 1'b0;
    end else begin
      timing_pin_o <= 1'b0;
      timing_pin_oe_n <= !((role_reg == bbps_pkg::BBPS_ROLE_MASTER) &&
                           (cnt_reg >= (period_reg >> bbps_pkg::SYNC_HIGH_SHIFT)));
    end
  end

  // ------------------------------------------------------------
  // Duty selection
  // ------------------------------------------------------------
  logic [6:0] duty_ceiling_pin_pct;    // Effective ceiling
  logic [6:0] cmp_pct;     // Duty asked by the loop
  logic [6:0] duty_pct;    // Duty after the soft-start limit
  logic [16:0] on_prod;    // Cycle length times duty
  logic [9:0] on_calc;     // On time for the next cycle
  logic [9:0] on_reg;      // On time of the current cycle

  assign duty_ceiling_pin_pct = bbps_pkg::bbps_min_pct(s_duty_ceiling_pin, bbps_pkg::DUTY_MAX_PCT);
  assign cmp_pct = s_err_hi ? duty_ceiling_pin_pct : bbps_pkg::bbps_min_pct(s_err_duty, duty_ceiling_pin_pct);
  assign duty_pct = s_err_lo ? bbps_pkg::DUTY_ZERO_PCT
                             : bbps_pkg::bbps_min_pct(cmp_pct, s_ss_duty);
  assign on_prod = 17'(len_now) * 17'(duty_pct);
  assign on_calc = 10'(on_prod / bbps_pkg::DUTY_FULL_PCT);

  // On time is fixed at the start of each switching cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      on_reg <= bbps_pkg::CNT_ZERO;
    end else if (cyc_start) begin
      on_reg <= on_calc;
    end
  end

  // ------------------------------------------------------------
  // Supervisor state machine and hiccup counters
  // ------------------------------------------------------------
  bbps_pkg::bbps_state_t state_reg;   // Supervisor state
  bbps_pkg::bbps_state_t state_next;  // Next supervisor state
  logic [9:0] oc_cnt_reg;             // Consecutive over-limit cycles
  logic [9:0] wait_cnt_reg;           // Suspended cycles so far
  logic hiccup_trip;                  // Over-limit run has passed its count
  logic wait_over;                    // Suspension has lasted its count

  assign hiccup_trip = cyc_start && s_cl &&
                       (oc_cnt_reg == bbps_pkg::HICCUP_TRIP_CYCLES);
  assign wait_over = cyc_start &&
                     (wait_cnt_reg == (bbps_pkg::HICCUP_WAIT_CYCLES - bbps_pkg::CNT_ONE));

  // Next state; any disable cause wins at once
  always_comb begin
    state_next = state_reg;
    if (disabled) begin
      state_next = bbps_pkg::BBPS_ST_OFF;
    end else begin
      case (state_reg)
        bbps_pkg::BBPS_ST_OFF: state_next = bbps_pkg::BBPS_ST_SOFT;
        bbps_pkg::BBPS_ST_SOFT: begin
          if (cyc_start && s_ss) begin
            state_next = bbps_pkg::BBPS_ST_RUN;
          end
        end
        bbps_pkg::BBPS_ST_RUN: begin
          if (hiccup_trip) begin
            state_next = bbps_pkg::BBPS_ST_HICCUP;
          end
        end
        bbps_pkg::BBPS_ST_HICCUP: begin
          if (wait_over) begin
            state_next = bbps_pkg::BBPS_ST_SOFT;
          end
        end
        default: state_next = bbps_pkg::BBPS_ST_OFF;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= bbps_pkg::BBPS_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Over-limit run counted once per cycle, cleared outside regulation
  always_ff @(posedge clk) begin
    if (srst || (state_reg != bbps_pkg::BBPS_ST_RUN) || disabled) begin
      oc_cnt_reg <= bbps_pkg::CNT_ZERO;
    end else if (cyc_start) begin
      oc_cnt_reg <= s_cl ? (oc_cnt_reg + bbps_pkg::CNT_ONE) : bbps_pkg::CNT_ZERO;
    end
  end

  // Suspension length counted in switching cycles
  always_ff @(posedge clk) begin
    if (srst || (state_reg != bbps_pkg::BBPS_ST_HICCUP) || disabled) begin
      wait_cnt_reg <= bbps_pkg::CNT_ZERO;
    end else if (cyc_start) begin
      wait_cnt_reg <= wait_cnt_reg + bbps_pkg::CNT_ONE;
    end
  end

  // ------------------------------------------------------------
  // Drive outputs and status
  // ------------------------------------------------------------
  logic pwm_on;  // Switch on in this core cycle

  assign pwm_on = (state_reg == bbps_pkg::BBPS_ST_RUN) && !disabled && !s_err_lo &&
                  (cnt_reg < on_reg);

  // Only the side chosen by the latched mode is ever pulsed
  always_ff @(posedge clk) begin
    if (srst) begin
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
    end else begin
      high_side_drive <= pwm_on && mode_reg;
      low_side_drive <= pwm_on && !mode_reg;
    end
  end

  // Soft-start held discharged while off or suspended
  always_ff @(posedge clk) begin
    if (srst) begin
      ss_discharge <= 1'b1;
      hiccup_active <= 1'b0;
      regulating <= 1'b0;
    end else begin
      ss_discharge <= (state_next == bbps_pkg::BBPS_ST_OFF) ||
                      (state_next == bbps_pkg::BBPS_ST_HICCUP);
      hiccup_active <= (state_next == bbps_pkg::BBPS_ST_HICCUP);
      regulating <= (state_next == bbps_pkg::BBPS_ST_RUN);
    end
  end

endmodule : bbps_top
`default_nettype wire

// *** common/bbps_pkg.sv ***
// Shared constants, types and helpers for the buck/boost PWM supervisor
package bbps_pkg;

  // ------------------------------------------------------------
  // Clock and switching rate
  // ------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 40000;       // Core clock rate in kHz
  localparam int unsigned RATE_SET_PIN_MIN_KHZ = 50;     // Slowest programmable switching rate
  localparam int unsigned RATE_SET_PIN_MAX_KHZ = 300;    // Fastest programmable switching rate
  localparam int PER_W = 10;                     // Width of period counts
  // Longest period rounds down, shortest period rounds up
  localparam logic [PER_W-1:0] PERIOD_MAX = PER_W'(CLK_KHZ / RATE_SET_PIN_MIN_KHZ);
  localparam logic [PER_W-1:0] PERIOD_MIN = PER_W'((CLK_KHZ + RATE_SET_PIN_MAX_KHZ - 1) / RATE_SET_PIN_MAX_KHZ);

  // ------------------------------------------------------------
  // Protection counts in switching cycles
  // ------------------------------------------------------------
  localparam logic [PER_W-1:0] HICCUP_TRIP_CYCLES = 10'h1f4;  // 500 cycles over limit
  localparam logic [PER_W-1:0] HICCUP_WAIT_CYCLES = 10'h1f4;  // 500 cycles suspended
  localparam logic [PER_W-1:0] CNT_ONE = 10'h001;             // Counter step
  localparam logic [PER_W-1:0] CNT_ZERO = 10'h000;            // Counter clear value

  // ------------------------------------------------------------
  // Duty cycle in whole percent
  // ------------------------------------------------------------
  localparam int DUTY_W = 7;                             // Width of percent values
  localparam logic [DUTY_W-1:0] DUTY_MAX_PCT = 7'h62;    // 98 percent internal ceiling
  localparam logic [DUTY_W-1:0] DUTY_ZERO_PCT = 7'h00;   // No drive
  localparam logic [16:0] DUTY_FULL_PCT = 17'h00064;     // 100 percent divisor
  localparam int SYNC_HIGH_SHIFT = 1;                    // 50 percent: half period high

  // ------------------------------------------------------------
  // Comparator thresholds behind the digital indications (mV)
  // ------------------------------------------------------------
  localparam int SS_ENABLE_MV = 520;     // Soft-start level that allows switching
  localparam int CL_REF_BUCK_MV = 300;   // Current-limit reference in buck mode
  localparam int CL_REF_BOOST_MV = 500;  // Current-limit reference in boost mode

  // ------------------------------------------------------------
  // Clock role level codes from the role comparators
  // ------------------------------------------------------------
  localparam logic [1:0] ROLE_CODE_SLAVE = 2'h0;   // Level at or below 0.5 V
  localparam logic [1:0] ROLE_CODE_SHIFT = 2'h1;   // Level between 0.65 V and 4.25 V
  localparam logic [1:0] ROLE_CODE_MASTER = 2'h3;  // Level at or above 4.53 V or floating

  // ------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BBPS_ROLE_MASTER = 3'b001,
    BBPS_ROLE_SLAVE = 3'b010,
    BBPS_ROLE_SHIFT = 3'b100
  } bbps_role_t;

  typedef enum logic [3:0] {
    BBPS_ST_OFF = 4'b0001,
    BBPS_ST_SOFT = 4'b0010,
    BBPS_ST_RUN = 4'b0100,
    BBPS_ST_HICCUP = 4'b1000
  } bbps_state_t;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Smaller of two percent values
  function automatic logic [DUTY_W-1:0] bbps_min_pct(input logic [DUTY_W-1:0] a,
                                                     input logic [DUTY_W-1:0] b);
    bbps_min_pct = (a < b) ? a : b;
  endfunction : bbps_min_pct

  // Keep a requested period inside the programmable range
  function automatic logic [PER_W-1:0] bbps_clamp_period(input logic [PER_W-1:0] p);
    bbps_clamp_period = (p < PERIOD_MIN) ? PERIOD_MIN : ((p > PERIOD_MAX) ? PERIOD_MAX : p);
  endfunction : bbps_clamp_period

endpackage : bbps_pkg

// *** hdl/bbps_sync.sv ***
// Two-flop synchroniser bank for inputs arriving from outside the core clock
`timescale 1ns/100ps
`default_nettype none

module bbps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  // ------------------------------------------------------------
  // Synchroniser chain
  // ------------------------------------------------------------
  logic [W-1:0] meta_reg;  // First stage, read only by the second stage

  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      // Each bit passes two flops before any logic reads it
      always_ff @(posedge clk) begin
        if (srst) begin
          meta_reg[gi] <= 1'b0;
          q_out[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= d_in[gi];
          q_out[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

endmodule : bbps_sync
`default_nettype wire

// *** hdl/bbps_link_edge.sv ***
// Timing-pin edge catcher running on the link clock, reporting edges as a toggle
`timescale 1ns/100ps
`default_nettype none

module bbps_link_edge (
  input wire logic link_clk,
  input wire logic srst,
  input wire logic pin_in,
  output logic edge_tgl
);

  // ------------------------------------------------------------
  // Reset carried into the link domain
  // ------------------------------------------------------------
  logic rst_meta_reg;  // First reset stage
  logic rst_reg;       // Link-domain reset

  // Two flops bring the core reset level across
  always_ff @(posedge link_clk) begin
    rst_meta_reg <= srst;
    rst_reg <= rst_meta_reg;
  end

  // ------------------------------------------------------------
  // Pin synchroniser and rising-edge toggle
  // ------------------------------------------------------------
  logic pin_meta_reg;  // First stage, read only by the second
  logic pin_sync_reg;  // Synchronised pin level
  logic pin_prev_reg;  // Level one link cycle earlier

  // Pin level passes two flops before use
  always_ff @(posedge link_clk) begin
    if (rst_reg) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Each rising edge flips the toggle so the core domain sees one event
  always_ff @(posedge link_clk) begin
    if (rst_reg) begin
      edge_tgl <= 1'b0;
    end else if (pin_sync_reg && !pin_prev_reg) begin
      edge_tgl <= !edge_tgl;
    end
  end

endmodule : bbps_link_edge
`default_nettype wire

// *** tb/bbps_top_asserts.sv ***
// Port assertions for the buck/boost PWM supervisor
`timescale 1ns/100ps
`default_nettype none
module bbps_top_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic fault_n,
  input wire logic over_temperature_shutdown,
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  input wire logic ss_discharge,
  input wire logic cl_ref_boost_sel,
  input wire logic buck_mode,
  input wire logic hiccup_active,
  input wire logic regulating
);
  // ----------------------------------------
  // Drive, protection and mode relations
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_boost_high_off: assert property (!buck_mode |-> !high_side_drive)
    else $error("high side pulses in boost");
  a_buck_low_off: assert property (buck_mode |-> !low_side_drive)
    else $error("low side pulses in buck");
  a_fault_quiet: assert property ((!fault_n)[*5] |->
    !(high_side_drive | low_side_drive) && ss_discharge) else $error("drive during fault");
  a_heat_quiet: assert property (over_temperature_shutdown[*5] |->
    !(high_side_drive | low_side_drive) && ss_discharge) else $error("drive during heat");
  a_ref_by_mode: assert property (cl_ref_boost_sel == !buck_mode)
    else $error("limit reference off mode");
  a_mode_held: assert property (regulating |=> $stable(buck_mode))
    else $error("mode moved while running");
  a_hiccup_soft: assert property (hiccup_active |-> ss_discharge && !regulating)
    else $error("hiccup without discharge");
  a_hiccup_quiet: assert property (hiccup_active[*2] |-> !(high_side_drive | low_side_drive))
    else $error("drive during hiccup");
  c_hiccup: cover property ($rose(hiccup_active));
  c_boost: cover property ($fell(buck_mode));
  c_run: cover property ($rose(regulating));
endmodule : bbps_top_asserts
`default_nettype wire

// *** tb/bbps_peer.sv ***
// Peer regulator model: open-drain clock source on the shared timing pin
`timescale 1ns/100ps
`default_nettype none
module bbps_peer #(
  parameter int HALF_NS = 1250
) (
  input wire logic run,
  output logic pull_low
);
  // Period slightly shorter than own rate; pin released when idle
  initial begin
    pull_low = 1'b0;
    forever #(HALF_NS) pull_low = run && !pull_low;
  end
endmodule : bbps_peer
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the buck/boost PWM supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // Ports, clocks and score
  // ----------------------------------------
  logic clk = 1'b0, link_clk = 1'b0, srst = 1'b1, peer_run = 1'b0, peer_pull;
  logic enable_ind, low_supply_lockout, fault_n, over_temperature_shutdown, internal_rail;
  logic mode_buck_ind, cl_over_ind, ss_ready_ind, error_low_ind, error_high_ind;
  logic [1:0] clock_role_select_level;
  logic [9:0] rate_set_pin, phase_delay_pin;
  logic [6:0] duty_ceiling_pin, error_duty_pct, ss_duty_pct;
  logic timing_pin_i, timing_pin_o, timing_pin_oe_n, high_side_drive, low_side_drive;
  logic ss_discharge, cl_ref_boost_sel, buck_mode, hiccup_active, regulating;
  logic [4:0] ctl; // Fault, heat, enable, rail, lockout; 5'h16 is all clear
  logic [4:0] cause [4] = '{5'h06, 5'h1e, 5'h10, 5'h17};
  int err_total = 0, n_checks = 0, seed = 38889, hs_n = 0, ls_n = 0, pin_n = 0, t, d, h0, l0, p0;
  assign {fault_n, over_temperature_shutdown, enable_ind, internal_rail, low_supply_lockout} = ctl;
  bbps_top bbps_top_i (.*);
  bbps_peer bbps_peer_i (.run(peer_run), .pull_low(peer_pull));
  assign timing_pin_i = !((!timing_pin_oe_n && !timing_pin_o) || peer_pull); // Pull-up
  initial forever #12.5 clk = ~clk;
  initial #37 forever #80 link_clk = ~link_clk;
  // Running high counts of both drives and the pin
  always @(posedge clk) begin
    hs_n += high_side_drive;
    ls_n += low_side_drive;
    pin_n += timing_pin_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g, input int tol);
    n_checks++;
    if (g !== e && (tol == 0 || g + tol < e || g > e + tol)) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk
  task automatic wait_on(input logic hic, input logic lvl, input int lim);
    for (t = 0; (hic ? hiccup_active : regulating) !== lvl && t < lim; t++) step(1);
  endtask : wait_on
  task automatic window(input int n);
    {h0, l0, p0} = {hs_n, ls_n, pin_n};
    step(n);
  endtask : window
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    ctl = 5'h16;
    {mode_buck_ind, ss_ready_ind, error_high_ind, cl_over_ind, error_low_ind} = 5'h1c;
    {duty_ceiling_pin, error_duty_pct, ss_duty_pct} = {7'h62, 7'h32, 7'h64};
    clock_role_select_level = bbps_pkg::ROLE_CODE_MASTER;
    {rate_set_pin, phase_delay_pin} = {10'h086, 10'h010}; // 134-clock own period
    step(2);
    chk("reset timing_pin_oe_n", 1, timing_pin_oe_n, 0);
    step(28);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      ctl = cause[i];
      {mode_buck_ind, ss_ready_ind, error_high_ind, error_low_ind} = {i == 2, 1'b0, i != 1, i == 3};
      duty_ceiling_pin = 7'($random(seed));
      error_duty_pct = 7'($unsigned($random(seed)) % 101);
      step(6);
      chk("drives off", 0, high_side_drive | low_side_drive, 0);
      chk("soft-start discharge", 1, ss_discharge, 0);
      ctl = 5'h16;
      step(670);
      chk("regulating early", 0, regulating, 0);
      ss_ready_ind = 1'b1;
      wait_on(1'b0, 1'b1, 1000);
      chk("buck_mode", i >= 2, buck_mode, 0);
      chk("cl_ref_boost_sel", i < 2, cl_ref_boost_sel, 0);
      d = (duty_ceiling_pin > 98) ? 98 : duty_ceiling_pin;
      d = (i == 3) ? 0 : (i == 1 && error_duty_pct < d) ? error_duty_pct : d;
      d = 4 * (134 * d / 100);
      window(402);
      window(536);
      chk("high side pulses", (i >= 2) ? d : 0, hs_n - h0, 0);
      chk("low side pulses", (i >= 2) ? 0 : d, ls_n - l0, 0);
      chk("timing pin high", 268, pin_n - p0, 0);
      $display("disable cause %0d done", i);
    end
    {clock_role_select_level, peer_run, error_low_ind} = {bbps_pkg::ROLE_CODE_SLAVE, 2'b10};
    step(1000);
    cl_over_ind = 1'b1;
    wait_on(1'b1, 1'b1, 60000);
    chk("cycles to hiccup", 50100, t, 300);
    cl_over_ind = 1'b0;
    wait_on(1'b1, 1'b0, 60000);
    chk("hiccup hold", 50000, t, 300);
    $display("hiccup done");
    clock_role_select_level = bbps_pkg::ROLE_CODE_SHIFT;
    wait_on(1'b0, 1'b1, 2000);
    window(800);
    window(500);
    d = 5 * ((duty_ceiling_pin > 98) ? 98 : duty_ceiling_pin); // Five outside cycles of 100 clocks
    chk("shift high side", d, hs_n - h0, 20);
    $display("shift done");
    end_of_test();
  end
  // Tests need about 2.8 ms; cut off at 4 ms
  initial begin
    #4000000;
    err_total++;
    end_of_test();
  end
endmodule : testbench
bind bbps_top bbps_top_asserts bbps_top_asserts_i (.*);
`default_nettype wire
